// ==== hw/ext_exec_pkg.sv ====
// Constants and types shared by the extended move and push execution logic
package ext_exec_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int OFS_W = 7;
	localparam int WORD_W = 16;

	// ----------------------------------------
	// Opcode fields
	// ----------------------------------------
	localparam logic [8:0] MOVE_W1_OPC = 9'h1d7;
	localparam logic [3:0] MOVE_W2_OPC = 4'hf;
	localparam logic [7:0] PUSH_OPC = 8'hfa;
	localparam int MOVE_W1_OPC_LSB = 7;
	localparam int MOVE_W2_OPC_LSB = 12;
	localparam int PUSH_OPC_LSB = 8;

	// ----------------------------------------
	// Special data memory locations (arbitrary placement)
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] PC_LOW_ADDR = 12'hf00;
	localparam logic [ADDR_W-1:0] RET_TOP_LOW_ADDR = 12'hf01;
	localparam logic [ADDR_W-1:0] RET_TOP_HIGH_ADDR = 12'hf02;
	localparam logic [ADDR_W-1:0] RET_TOP_UPPER_ADDR = 12'hf03;
	localparam logic [ADDR_W-1:0] INDIRECT_BASE_ADDR = 12'hf10;
	localparam logic [ADDR_W-1:0] INDIRECT_LAST_ADDR = 12'hf1e;

	// ----------------------------------------
	// Reset values and phases
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] FP_RESET = 12'h000;
	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
	localparam logic [DATA_W-1:0] INDIRECT_READ_VALUE = 8'h00;
	localparam logic [ADDR_W-1:0] FP_STEP = 12'h001;

	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} phase_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MOVE_SRC = 2'b01,
		ST_MOVE_DST = 2'b10,
		ST_PUSH = 2'b11
	} exec_state_t;

endpackage

// ==== hw/indexed_addr_unit.sv ====
// Frame pointer plus offset adder with special register classification
`timescale 1ns/1ps
`default_nettype none

module indexed_addr_unit
	import ext_exec_pkg::*;
(
	input wire logic [ADDR_W-1:0] frame_pointer_i,
	input wire logic [OFS_W-1:0] offset_i,
	output logic [ADDR_W-1:0] addr_o,
	output logic indirect_o,
	output logic protected_o
);

	// Full 12-bit reach, wraps past FFFh
	assign addr_o = ADDR_W'(frame_pointer_i + {{(ADDR_W-OFS_W){1'b0}}, offset_i});

	assign indirect_o = (addr_o >= INDIRECT_BASE_ADDR) && (addr_o <= INDIRECT_LAST_ADDR);

	assign protected_o = (addr_o == PC_LOW_ADDR) || (addr_o == RET_TOP_LOW_ADDR) ||
		(addr_o == RET_TOP_HIGH_ADDR) || (addr_o == RET_TOP_UPPER_ADDR);

endmodule

`default_nettype wire

// ==== hw/indexed_move_and_push_exec.sv ====
// Execution of the indexed-to-indexed move and the literal stack push
//
// Behaviour
// - Source and destination addresses are frame pointer plus a 7-bit unsigned offset.
// - Computed addresses may reach any byte of the 000h..FFFh data space.
// - The move never writes the program counter low byte or the three return stack top bytes.
// - A source address on an indirect-addressing register reads as zero.
// - A destination address on an indirect-addressing register makes the move a no-op.
// - The move is word one 1110 1011 1 + source offset, word two 1111 xxxx x + dest offset.
// - Move cycle one decodes in Q1, forms the source address in Q2-Q3, reads in Q4.
// - Move cycle two decodes in Q1, forms the dest address in Q2-Q3, writes in Q4.
// - The push writes its 8-bit literal at the frame pointer address.
// - After the store the push decrements the frame pointer by one.
// - The push is the single word with upper byte 1111 1010 and the literal below.
// - Neither instruction changes any arithmetic status flag.
// - Both start only while the extended instruction set is enabled; move word two is decoded without that check.
`timescale 1ns/1ps
`default_nettype none

module indexed_move_and_push_exec
	import ext_exec_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ext_enable_i,
	input wire logic instr_valid_i,
	input wire logic [WORD_W-1:0] instr_word_i,
	input wire logic fp_load_i,
	input wire logic [ADDR_W-1:0] fp_load_value_i,
	input wire logic [DATA_W-1:0] mem_rdata_i,
	output logic [1:0] phase_o,
	output logic [ADDR_W-1:0] mem_addr_o,
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [DATA_W-1:0] mem_wdata_o,
	output logic [ADDR_W-1:0] frame_pointer_o,
	output logic expect_second_word_o,
	output logic instr_done_o,
	output logic status_write_o
);

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	function automatic logic is_move_first(input logic [WORD_W-1:0] w);
		is_move_first = (w[WORD_W-1:MOVE_W1_OPC_LSB] == MOVE_W1_OPC);
	endfunction

	function automatic logic is_move_second(input logic [WORD_W-1:0] w);
		is_move_second = (w[WORD_W-1:MOVE_W2_OPC_LSB] == MOVE_W2_OPC);
	endfunction

	function automatic logic is_push(input logic [WORD_W-1:0] w);
		is_push = (w[WORD_W-1:PUSH_OPC_LSB] == PUSH_OPC);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	phase_t phase;
	exec_state_t state;
	logic [ADDR_W-1:0] frame_pointer;
	logic [OFS_W-1:0] offset;
	logic [DATA_W-1:0] literal;
	logic [DATA_W-1:0] move_data;
	logic suppress;
	logic [ADDR_W-1:0] calc_addr;
	logic calc_indirect;
	logic calc_protected;
	logic decode_now;

	assign decode_now = (phase == PH_Q1) && instr_valid_i;

	indexed_addr_unit u_addr (
		.frame_pointer_i(frame_pointer),
		.offset_i(offset),
		.addr_o(calc_addr),
		.indirect_o(calc_indirect),
		.protected_o(calc_protected)
	);

	// ----------------------------------------
	// Phase counter: four clocks per instruction cycle
	// ----------------------------------------
	// Free-running: the core never stalls, so every instruction cycle is four clocks
	// and the first clock after reset is always Q1.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase <= PH_Q1;
		end else begin
			phase <= phase_t'(phase + 2'b01);
		end
	end

	// ----------------------------------------
	// Decode in Q1
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
		end else if (phase == PH_Q1) begin
			// Every Q1 starts from idle: a move whose second word is missing or malformed
			// is dropped whole rather than writing through a stale offset.
			state <= ST_IDLE;
			if (state == ST_MOVE_SRC) begin
				// Second word decoded in cycle two
				// No extension gate here: word two only follows a first word that passed it
				if (instr_valid_i && is_move_second(instr_word_i)) begin
					state <= ST_MOVE_DST;
				end
			end else if (decode_now && ext_enable_i) begin
				if (is_move_first(instr_word_i)) begin
					state <= ST_MOVE_SRC;
				end else if (is_push(instr_word_i)) begin
					state <= ST_PUSH;
				end
			end
		end
	end

	// Offset field latched with the word that carries it
	// Latched even when nothing decodes; it is only read once a move is under way
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			offset <= '0;
		end else if (decode_now) begin
			offset <= instr_word_i[OFS_W-1:0];
		end
	end

	// ----------------------------------------
	// Literal fetch, Q1
	// ----------------------------------------
	// Literal taken at the end of Q1, together with the decode
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			literal <= DATA_RESET;
		end else if (decode_now) begin
			literal <= instr_word_i[DATA_W-1:0];
		end
	end

	// ----------------------------------------
	// Address formation, Q2 and Q3
	// ----------------------------------------
	// The adder output is classified here and the verdict kept in a flop, so the
	// Q4 capture never depends on an address the frame pointer may move under.
	// Source or destination address classified at end of Q3
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			suppress <= 1'b0;
		end else if (phase == PH_Q3) begin
			unique case (state)
				ST_MOVE_SRC: begin
					suppress <= calc_indirect;
				end
				ST_MOVE_DST: begin
					suppress <= calc_indirect || calc_protected;
				end
				ST_PUSH: begin
					suppress <= 1'b0;
				end
				ST_IDLE: begin
					suppress <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Memory strobes, active through Q4
	// ----------------------------------------
	// Set at the Q3 edge so each strobe stands for exactly the Q4 clock
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_addr_o <= '0;
			mem_rd_o <= 1'b0;
			mem_wr_o <= 1'b0;
			mem_wdata_o <= DATA_RESET;
		end else if (phase == PH_Q3) begin
			mem_rd_o <= 1'b0;
			mem_wr_o <= 1'b0;
			unique case (state)
				ST_MOVE_SRC: begin
					mem_addr_o <= calc_addr;
					mem_rd_o <= !calc_indirect;
				end
				ST_MOVE_DST: begin
					mem_addr_o <= calc_addr;
					mem_wdata_o <= move_data;
					mem_wr_o <= !(calc_indirect || calc_protected);
				end
				ST_PUSH: begin
					mem_addr_o <= frame_pointer;
					mem_wdata_o <= literal;
					mem_wr_o <= 1'b1;
				end
				ST_IDLE: begin
					// Address held so the bus does not toggle without a strobe
					mem_addr_o <= mem_addr_o;
				end
			endcase
		end else if (phase == PH_Q4) begin
			mem_rd_o <= 1'b0;
			mem_wr_o <= 1'b0;
		end
	end

	// ----------------------------------------
	// Source data capture at the end of Q4
	// ----------------------------------------
	// Read data outside Q4 may be junk; only this edge looks at it
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			move_data <= DATA_RESET;
		end else if ((phase == PH_Q4) && (state == ST_MOVE_SRC)) begin
			move_data <= suppress ? INDIRECT_READ_VALUE : mem_rdata_i;
		end
	end

	// ----------------------------------------
	// Frame pointer
	// ----------------------------------------
	// Software load loses to a push in the same Q4 so the stack stays consistent.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			frame_pointer <= FP_RESET;
		end else if ((phase == PH_Q4) && (state == ST_PUSH)) begin
			frame_pointer <= frame_pointer - FP_STEP;
		end else if (fp_load_i) begin
			frame_pointer <= fp_load_value_i;
		end
	end

	// Output copy follows the same rule so the port comes straight from a flop
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			frame_pointer_o <= FP_RESET;
		end else if ((phase == PH_Q4) && (state == ST_PUSH)) begin
			frame_pointer_o <= frame_pointer - FP_STEP;
		end else if (fp_load_i) begin
			frame_pointer_o <= fp_load_value_i;
		end
	end

	// ----------------------------------------
	// Handshake and status outputs
	// ----------------------------------------
	// Twin of the phase counter, kept separate so the port is registered
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase_o <= PH_Q1;
		end else begin
			phase_o <= phase_t'(phase + 2'b01);
		end
	end

	// High through the whole of the cycle in which word two must be offered
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			expect_second_word_o <= 1'b0;
		end else if (phase == PH_Q4) begin
			expect_second_word_o <= (state == ST_MOVE_SRC);
		end
	end

	// One-clock pulse after the last Q4 of an instruction, suppressed moves included
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			instr_done_o <= 1'b0;
		end else begin
			instr_done_o <= (phase == PH_Q4) &&
				((state == ST_PUSH) || (state == ST_MOVE_DST));
		end
	end

	// Kept as a port so the flag logic of the core can rely on never being written here
	// Flags never written
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			status_write_o <= 1'b0;
		end else begin
			status_write_o <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ==== verif/indexed_move_and_push_exec_assertions.sv ====
// Port-level checker for the indexed move and literal push execution block
`timescale 1ns/1ps
`default_nettype none

module exec_checker
	import ext_exec_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ext_enable_i,
	input wire logic instr_valid_i,
	input wire logic [WORD_W-1:0] instr_word_i,
	input wire logic [1:0] phase_o,
	input wire logic [ADDR_W-1:0] mem_addr_o,
	input wire logic mem_rd_o,
	input wire logic mem_wr_o,
	input wire logic [DATA_W-1:0] mem_wdata_o,
	input wire logic [ADDR_W-1:0] frame_pointer_o,
	input wire logic expect_second_word_o,
	input wire logic instr_done_o,
	input wire logic status_write_o
);
	logic take_q1;
	logic take_push;
	logic take_move;
	logic [DATA_W-1:0] lit;
	logic [OFS_W-1:0] ofs;

	// Word two arrives while expect_second_word_o is high, so it is never a new opcode
	assign take_q1 = phase_o == 2'h0 && instr_valid_i && !expect_second_word_o;
	assign take_push = take_q1 && ext_enable_i && instr_word_i[15:8] == PUSH_OPC;
	assign take_move = take_q1 && ext_enable_i && instr_word_i[15:7] == MOVE_W1_OPC;
	assign lit = instr_word_i[DATA_W-1:0];
	assign ofs = instr_word_i[OFS_W-1:0];

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_PUSH_WR: assert property (take_push |-> ##3 mem_wr_o &&
		mem_addr_o == $past(frame_pointer_o, 3) && mem_wdata_o == $past(lit, 3))
		else $error("push store wrong");
	AST_PUSH_FP: assert property (take_push |-> ##4
		frame_pointer_o == $past(frame_pointer_o, 4) - FP_STEP)
		else $error("push pointer step wrong");
	AST_MOVE_RD: assert property (take_move |-> ##3
		(!mem_rd_o || mem_addr_o == $past(frame_pointer_o, 3) + $past(ofs, 3))
		##1 expect_second_word_o [*4])
		else $error("move source phase wrong");
	AST_STROBE_Q4: assert property ((mem_rd_o || mem_wr_o) |-> phase_o == 2'h3)
		else $error("strobe outside fourth phase");
	AST_DONE: assert property (mem_wr_o |=> instr_done_o && phase_o == 2'h0)
		else $error("done missing after write");
	AST_NO_FLAGS: assert property (!status_write_o)
		else $error("status flag written");
	AST_EXT_OFF: assert property (take_q1 && !ext_enable_i |-> ##3 !mem_wr_o && !mem_rd_o)
		else $error("executed while disabled");
	AST_DST_SAFE: assert property (mem_wr_o && expect_second_word_o |->
		!(mem_addr_o inside {[PC_LOW_ADDR:RET_TOP_UPPER_ADDR],
		[INDIRECT_BASE_ADDR:INDIRECT_LAST_ADDR]}))
		else $error("move wrote a forbidden place");

	cover property (take_push ##3 mem_wr_o);
	cover property (mem_rd_o);
	cover property (mem_wr_o && expect_second_word_o);
endmodule

bind indexed_move_and_push_exec exec_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.ext_enable_i(ext_enable_i), .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i),
	.phase_o(phase_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
	.mem_wdata_o(mem_wdata_o), .frame_pointer_o(frame_pointer_o),
	.expect_second_word_o(expect_second_word_o), .instr_done_o(instr_done_o),
	.status_write_o(status_write_o));

`default_nettype wire

// ==== verif/data_mem_model.sv ====
// Behavioural data memory answering the execution block's strobes
`timescale 1ns/1ps
`default_nettype none

module data_mem_model
	import ext_exec_pkg::*;
(
	input wire logic clk_i,
	input wire logic [ADDR_W-1:0] mem_addr_i,
	input wire logic mem_rd_i,
	input wire logic mem_wr_i,
	input wire logic [DATA_W-1:0] mem_wdata_i,
	output logic [DATA_W-1:0] mem_rdata_o
);
	logic [DATA_W-1:0] mem [0:4095];
	logic [DATA_W-1:0] last;

	// Seed pattern lets the bench predict every byte without a copy
	initial begin
		for (int a = 0; a < 4096; a++) mem[a] = 8'(a) ^ 8'h5a;
		last = 8'h00;
	end

	always @(posedge clk_i) begin
		if (mem_wr_i) mem[mem_addr_i] <= mem_wdata_i;
		if (mem_rd_i) last <= mem[mem_addr_i];
	end

	// Outside a read the bus shows junk, so a late sample cannot pass by luck
	assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : ~last;
endmodule

`default_nettype wire

// ==== verif/indexed_move_and_push_exec_tb_top.sv ====
// Self-checking bench for the indexed move and literal push execution block
`timescale 1ns/1ps
`default_nettype none

module indexed_move_and_push_exec_tb_top;
	import ext_exec_pkg::*;
	logic clk_i = 0, rst_i = 1, ext_enable_i = 1, instr_valid_i = 0, fp_load_i = 0;
	logic [WORD_W-1:0] instr_word_i = 16'h0000;
	logic [ADDR_W-1:0] fp_load_value_i = 12'h000, mem_addr_o, frame_pointer_o;
	logic [DATA_W-1:0] mem_rdata_i, mem_wdata_o;
	logic [1:0] phase_o;
	logic mem_rd_o, mem_wr_o, expect_second_word_o, instr_done_o, status_write_o;
	int bad_count = 0, total_checks = 0;

	indexed_move_and_push_exec uut (.clk_i(clk_i), .rst_i(rst_i), .ext_enable_i(ext_enable_i),
		.instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i), .fp_load_i(fp_load_i),
		.fp_load_value_i(fp_load_value_i), .mem_rdata_i(mem_rdata_i), .phase_o(phase_o),
		.mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
		.mem_wdata_o(mem_wdata_o), .frame_pointer_o(frame_pointer_o),
		.expect_second_word_o(expect_second_word_o), .instr_done_o(instr_done_o),
		.status_write_o(status_write_o));
	data_mem_model mem_model (.clk_i(clk_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
		.mem_wr_i(mem_wr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] pat(input logic [11:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction

	task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic setfp(input logic [11:0] v, input logic en);
		@(posedge clk_i);
		fp_load_i <= 1;
		fp_load_value_i <= v;
		ext_enable_i <= en;
		@(posedge clk_i);
		fp_load_i <= 0;
	endtask

	// Presents a word for the clock whose phase is Q1
	task automatic issue(input logic [15:0] w);
		int i;
		// Looks only at negedges, so a port still settling after a posedge is never read
		for (i = 0; i < 8; i++) begin
			@(negedge clk_i);
			if (phase_o === 2'h3) break;
		end
		if (i == 8) begin
			bad_count++;
			close_out();
		end
		@(posedge clk_i);
		instr_valid_i <= 1;
		instr_word_i <= w;
		@(posedge clk_i);
		instr_valid_i <= 0;
	endtask

	task automatic wait_wr(output bit seen);
		seen = 0;
		for (int i = 0; i < 8 && !seen; i++) begin
			@(negedge clk_i);
			seen = (mem_wr_o === 1'b1);
		end
	endtask

	task automatic run_push(input logic [7:0] k, input logic [11:0] fp, input logic en);
		bit seen;
		logic [11:0] fp_next;
		setfp(fp, en);
		fp_next = en ? 12'(fp - FP_STEP) : fp;
		issue({PUSH_OPC, k});
		wait_wr(seen);
		check("push write", 16'(seen), 16'(en));
		if (seen) begin
			check("push addr", 16'(mem_addr_o), 16'(fp));
			check("push data", 16'(mem_wdata_o), 16'(k));
			@(negedge clk_i);
			check("push done", 16'(instr_done_o), 16'h0001);
		end
		check("push fp", 16'(frame_pointer_o), 16'(fp_next));
		check("flags", 16'(status_write_o), 16'h0000);
	endtask

	task automatic run_move(input logic [11:0] fp, input logic [6:0] s, input logic [6:0] d,
		input logic [3:0] w2hi, input bit exp_wr, input logic [7:0] exp_data);
		bit seen;
		setfp(fp, 1'b1);
		issue({MOVE_W1_OPC, s});
		issue({w2hi, 5'h1b, d});
		wait_wr(seen);
		check("move write", 16'(seen), 16'(exp_wr));
		if (seen) begin
			check("move addr", 16'(mem_addr_o), 16'(12'(fp + 12'(d))));
			check("move data", 16'(mem_wdata_o), 16'(exp_data));
			@(negedge clk_i);
			check("move done", 16'(instr_done_o), 16'h0001);
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_push;
		run_push(8'h08, 12'h1ec, 1'b1);
		run_push(8'hff, 12'h000, 1'b1);
		run_push(8'h3c, 12'h200, 1'b0);
	endtask

	task automatic t_move_plain;
		run_move(12'h080, 7'h05, 7'h06, 4'hf, 1, pat(12'h085));
		run_move(12'hf80, 7'h7f, 7'h7e, 4'hf, 1, pat(12'hfff));
		run_move(12'h080, 7'h01, 7'h02, 4'he, 0, 8'h00);
	endtask

	task automatic t_move_special;
		for (int a = 0; a < 4; a++) run_move(12'hf00, 7'h20, 7'(a), 4'hf, 0, 8'h00);
		run_move(12'hf10, 7'h20, 7'h0e, 4'hf, 0, 8'h00);
		run_move(12'hf10, 7'h05, 7'h7f, 4'hf, 1, 8'h00);
	endtask

	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 0;
		t_push();
		t_move_plain();
		t_move_special();
		close_out();
	end
endmodule

`default_nettype wire
